/* static_clock_ready_controller.sv */
// Static clock controller: dividers, speed, stop and restart, reset pulse and ready logic.
`timescale 1ns/1ps
`default_nettype none
`include "clock_ctrl_map.svh"

// Functional notes
// - Each bus ready counts only while its own active-low address enable is low.
// - Depth select low gives two ready stages; high gives one stage.
// - Active-high ready output lets the processor finish the pending transfer.
// - After oscillator restart, clocks stay high until reset released and 8192 counted.
// - Reset output stays high at least 16 processor clocks after clocks start.
// - Speed changes are taken on a peripheral clock edge, else the next one.
// - Processor clock divides input by 3 in fast mode and 768 in slow.
// - Crystal or external input; fast, slow, stop-clock and stop-oscillator modes.
// - Shared stop and start controls for oscillator and clock outputs.
// - Counter sync input lets several controllers run clocks in phase.
// - Halt decode on status lines enters stop mode automatically.
// - Clocks restart cleanly, mutually in phase, without truncated pulses.
// - Peripheral clock is input divided by six at 50% duty in both fast and slow modes.
// - Counter sync high while running resets counters and forces all three clocks high.
// - Idle then halt status stops clocks high after two cycles, peripheral frozen.
module static_clock_ready_controller #(
  parameter int OSC_RESTART_CYCLES = `OSC_RESTART_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        bus_ready_a_i,
  input  wire logic        bus_ready_b_i,
  input  wire logic        addr_qualify_a_n_i,
  input  wire logic        addr_qualify_b_n_i,
  input  wire logic        ready_sync_depth_sel_i,
  input  wire logic        speed_select_i,
  input  wire logic        reset_request_n_i,
  input  wire logic        counter_sync_i,
  input  wire logic        start_request_i,
  input  wire logic        status_line_0_i,
  input  wire logic        status_line_1_i,
  input  wire logic        status_line_2_stop_n_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             ready_o,
  output logic             proc_clock_o,
  output logic             half_duty_clock_o,
  output logic             periph_clock_o,
  output logic             oscillator_out_o,
  output logic             reset_out_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release.

  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Timing events.

  clock_ctrl_pkg::ctrl_state_t s_q;
  clock_ctrl_pkg::ctrl_state_t s_d;

  logic        running;
  logic        rise_en;
  logic        per_edge;
  logic [9:0]  period;
  logic [13:0] osc_last;
  logic        osc_done;
  logic [2:0]  status;
  logic        start_trig;
  logic        qual;
  logic        mapped;
  logic [9:0]  high_len;
  logic [9:0]  half_low;

  assign running    = (s_q.state == clock_ctrl_pkg::ST_RUN)
                   || (s_q.state == clock_ctrl_pkg::ST_STOP_PEND);
  assign period     = s_q.slow ? `SLOW_DIV : `FAST_DIV;
  assign rise_en    = running && !counter_sync_i && (s_q.div_cnt == period - 10'h001);
  assign per_edge   = running && !counter_sync_i && (s_q.per_cnt == `PER_LAST);
  assign osc_last   = 14'(OSC_RESTART_CYCLES - 1);
  assign osc_done   = (s_q.osc_cnt == osc_last);
  assign status     = {status_line_2_stop_n_i, status_line_1_i, status_line_0_i};
  assign start_trig = start_request_i || s_q.soft_start || !reset_request_n_i;
  assign qual       = (bus_ready_a_i && !addr_qualify_a_n_i)
                   || (bus_ready_b_i && !addr_qualify_b_n_i);
  assign mapped     = (paddr == `ADDR_CTRL) || (paddr == `ADDR_STATUS);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    s_d = s_q;
    s_d.soft_start = 1'b0;
    high_len = `FAST_HIGH;
    half_low = `FAST_HALF_LOW;

    // Register bus: read data is captured in the setup cycle.
    if (psel && !penable && !pwrite) begin
      s_d.prdata = 32'h0000_0000;
      if (paddr == `ADDR_CTRL) begin
        s_d.prdata[`CTRL_EFI_BIT] = s_q.efi_mode;
      end else if (paddr == `ADDR_STATUS) begin
        s_d.prdata[`STAT_SLOW_BIT]    = s_q.slow;
        s_d.prdata[`STAT_OSC_BIT]     = s_q.osc_run;
        s_d.prdata[`STAT_STOPPED_BIT] = (s_q.state == clock_ctrl_pkg::ST_STOPPED);
        s_d.prdata[`STAT_RESET_BIT]   = s_q.reset_out;
        s_d.prdata[`STAT_STATE_HI:`STAT_STATE_LO] = s_q.state;
      end
    end
    if (psel && penable && pwrite && (paddr == `ADDR_CTRL)) begin
      s_d.efi_mode   = pwdata[`CTRL_EFI_BIT];
      s_d.soft_start = pwdata[`CTRL_START_BIT];
    end

    // Speed select filter: long low for slow, short high for fast.
    if (speed_select_i) begin
      s_d.low_cnt = 8'h00;
      if (s_q.high_cnt != `FAST_FILTER) begin
        s_d.high_cnt = s_q.high_cnt + 3'h1;
      end else begin
        s_d.filt_slow = 1'b0;
      end
    end else begin
      s_d.high_cnt = 3'h0;
      if (s_q.low_cnt != `SLOW_FILTER) begin
        s_d.low_cnt = s_q.low_cnt + 8'h01;
      end else begin
        s_d.filt_slow = 1'b1;
      end
    end

    // Dividers run only while clocks are active.
    if (running) begin
      if (counter_sync_i) begin
        s_d.div_cnt = 10'h000;
        s_d.per_cnt = 2'h0;
        s_d.per_clk = 1'b1;
      end else begin
        s_d.div_cnt = rise_en ? 10'h000 : s_q.div_cnt + 10'h001;
        if (rise_en) begin
          s_d.slow = s_q.speed_seen;
        end
        s_d.per_cnt = per_edge ? 2'h0 : s_q.per_cnt + 2'h1;
        if (per_edge) begin
          s_d.per_clk    = ~s_q.per_clk;
          s_d.speed_seen = s_q.filt_slow;
        end
      end
    end

    unique case (s_q.state)
      clock_ctrl_pkg::ST_RESTART: begin
        if (!osc_done) begin
          s_d.osc_cnt = s_q.osc_cnt + 14'h0001;
        end else if (reset_request_n_i) begin
          s_d.state     = clock_ctrl_pkg::ST_RUN;
          s_d.div_cnt   = 10'h000;
          s_d.per_cnt   = 2'h0;
          s_d.per_clk   = 1'b1;
          s_d.slow      = s_q.speed_seen;
          s_d.prev_idle = 1'b0;
        end
      end
      clock_ctrl_pkg::ST_RUN: begin
        if (rise_en) begin
          s_d.prev_idle = (status == `STATUS_IDLE);
          if ((status == `STATUS_HALT) && s_q.prev_idle) begin
            s_d.state    = clock_ctrl_pkg::ST_STOP_PEND;
            s_d.stop_cnt = 2'h0;
          end
        end
      end
      clock_ctrl_pkg::ST_STOP_PEND: begin
        if (rise_en) begin
          s_d.stop_cnt = s_q.stop_cnt + 2'h1;
          if (s_q.stop_cnt + 2'h1 == `HALT_STOP_CLKS) begin
            s_d.state   = clock_ctrl_pkg::ST_STOPPED;
            s_d.osc_run = s_q.efi_mode;
          end
        end
      end
      clock_ctrl_pkg::ST_STOPPED: begin
        if (start_trig) begin
          s_d.state   = clock_ctrl_pkg::ST_RESTART;
          s_d.osc_cnt = s_q.osc_run ? osc_last : 14'h0000;
          s_d.osc_run = 1'b1;
        end
      end
    endcase

    // Reset output pulse.
    if (!reset_request_n_i) begin
      s_d.reset_out = 1'b1;
      s_d.rst_cnt   = 5'h00;
    end else if (s_q.reset_out && rise_en) begin
      s_d.rst_cnt   = s_q.rst_cnt + 5'h01;
      s_d.reset_out = (s_q.rst_cnt + 5'h01 != `RESET_MIN_CLKS);
    end

    // Clock outputs from the next counter values.
    if (s_d.slow) begin
      high_len = `SLOW_HIGH;
      half_low = `SLOW_HALF_LOW;
    end
    s_d.osc_out = s_d.osc_run ? ~s_q.osc_out : 1'b1;
    if ((s_d.state == clock_ctrl_pkg::ST_RUN || s_d.state == clock_ctrl_pkg::ST_STOP_PEND)
        && !counter_sync_i) begin
      s_d.proc_clk = s_d.div_cnt < high_len;
      s_d.half_clk = !((s_d.div_cnt >= high_len) && (s_d.div_cnt < high_len + half_low));
    end else begin
      s_d.proc_clk = 1'b1;
      s_d.half_clk = 1'b1;
      if (s_d.state == clock_ctrl_pkg::ST_RESTART) begin
        s_d.per_clk = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.state     <= clock_ctrl_pkg::ST_RESTART;
      s_q.osc_run   <= 1'b1;
      s_q.osc_out   <= 1'b1;
      s_q.per_clk   <= 1'b1;
      s_q.proc_clk  <= 1'b1;
      s_q.half_clk  <= 1'b1;
      s_q.reset_out <= 1'b1;
      s_q.efi_mode  <= 1'(`CTRL_RESET >> `CTRL_EFI_BIT);
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Ready path and outputs.

  ready_sync u_ready_sync (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .en_i        (rise_en),
    .two_stage_i (!ready_sync_depth_sel_i),
    .d_i         (qual),
    .q_o         (ready_o)
  );

  assign prdata            = s_q.prdata;
  assign pready            = 1'b1;
  assign pslverr           = psel && penable && !mapped;
  assign proc_clock_o      = s_q.proc_clk;
  assign half_duty_clock_o = s_q.half_clk;
  assign periph_clock_o    = s_q.per_clk;
  assign oscillator_out_o  = s_q.osc_out;
  assign reset_out_o       = s_q.reset_out;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  sequence idle_then_halt_s;
    rise_en && s_q.state == clock_ctrl_pkg::ST_RUN && s_q.prev_idle && status == `STATUS_HALT;
  endsequence

  sequence stop_entered_s;
    s_q.state == clock_ctrl_pkg::ST_STOP_PEND;
  endsequence

  ready_single_stage_a : assert property ((rise_en && ready_sync_depth_sel_i) |=> ready_o == $past(qual))
    else $error("Single-stage ready did not follow the qualified input.");
  ready_unqualified_a : assert property ((rise_en && ready_sync_depth_sel_i && addr_qualify_a_n_i
                                          && addr_qualify_b_n_i) |=> !ready_o)
    else $error("Ready passed while both address enables were high.");
  restart_hold_a : assert property ((s_q.state == clock_ctrl_pkg::ST_RESTART)
                                    |-> (proc_clock_o && half_duty_clock_o && periph_clock_o))
    else $error("Clocks active during oscillator restart.");
  restart_count_a : assert property (($past(s_q.state) == clock_ctrl_pkg::ST_RESTART
                                      && s_q.state == clock_ctrl_pkg::ST_RUN)
                                     |-> ($past(osc_done) && $past(reset_request_n_i)))
    else $error("Clocks started before restart count ended.");
  reset_min_a : assert property ($fell(reset_out_o) |-> s_q.rst_cnt == `RESET_MIN_CLKS)
    else $error("Reset output fell before sixteen processor clocks.");
  fast_divide_a : assert property ((running && !s_q.slow) |-> s_q.div_cnt < `FAST_DIV)
    else $error("Fast divider ran past its period.");
  periph_edge_a : assert property (per_edge |=> ((periph_clock_o != $past(periph_clock_o))
                                   && !per_edge) ##1 !per_edge)
    else $error("Peripheral clock did not divide by six.");
  speed_on_edge_a : assert property ($changed(s_q.speed_seen) |-> $past(per_edge))
    else $error("Speed change taken off a peripheral edge.");
  sync_force_a : assert property ((running && counter_sync_i) |=> (proc_clock_o
                                   && half_duty_clock_o && periph_clock_o))
    else $error("Counter sync did not force the clocks high.");
  halt_stop_a : assert property (idle_then_halt_s |=> stop_entered_s)
    else $error("Halt after idle did not enter stop.");
  stopped_high_a : assert property ((s_q.state == clock_ctrl_pkg::ST_STOPPED)
                                    |-> (proc_clock_o && half_duty_clock_o
                                         && (s_q.osc_run == s_q.efi_mode)))
    else $error("Stopped state with clocks low or wrong oscillator state.");

endmodule : static_clock_ready_controller

`default_nettype wire

/* clock_ctrl_map.svh */
// Offsets, field positions, reset values and timing counts of the clock controller.
`ifndef CLOCK_CTRL_MAP_SVH
`define CLOCK_CTRL_MAP_SVH

`define ADDR_CTRL          12'h000
`define ADDR_STATUS        12'h004
`define CTRL_RESET         32'h0000_0000
`define CTRL_EFI_BIT       0
`define CTRL_START_BIT     1
`define STAT_SLOW_BIT      0
`define STAT_OSC_BIT       1
`define STAT_STOPPED_BIT   2
`define STAT_RESET_BIT     3
`define STAT_STATE_LO      4
`define STAT_STATE_HI      5

`define FAST_DIV           10'h003
`define SLOW_DIV           10'h300
`define FAST_HIGH          10'h001
`define SLOW_HIGH          10'h100
`define FAST_HALF_LOW      10'h002
`define SLOW_HALF_LOW      10'h180
`define PER_LAST           2'h2
`define SLOW_FILTER        8'hC3
`define FAST_FILTER        3'h6
`define OSC_RESTART_CYCLES 32'h0000_2000
`define RESET_MIN_CLKS     5'h10
`define HALT_STOP_CLKS     2'h2
`define STATUS_IDLE        3'h7
`define STATUS_HALT        3'h3

`endif

/* clock_ctrl_pkg.sv */
// Types shared by the clock controller modules.
package clock_ctrl_pkg;

  typedef enum logic [1:0] {
    ST_RESTART   = 2'h0,
    ST_RUN       = 2'h1,
    ST_STOP_PEND = 2'h3,
    ST_STOPPED   = 2'h2
  } run_state_t;

  typedef struct packed {
    run_state_t  state;
    logic [13:0] osc_cnt;
    logic        osc_run;
    logic        osc_out;
    logic [9:0]  div_cnt;
    logic        slow;
    logic [1:0]  per_cnt;
    logic        per_clk;
    logic        proc_clk;
    logic        half_clk;
    logic [7:0]  low_cnt;
    logic [2:0]  high_cnt;
    logic        filt_slow;
    logic        speed_seen;
    logic        prev_idle;
    logic [1:0]  stop_cnt;
    logic [4:0]  rst_cnt;
    logic        reset_out;
    logic        efi_mode;
    logic        soft_start;
    logic [31:0] prdata;
  } ctrl_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
  } sync_state_t;

endpackage : clock_ctrl_pkg

/* ready_sync.sv */
// Ready synchroniser with one or two stages, advanced on processor clock edges.
`timescale 1ns/1ps
`default_nettype none

module ready_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic en_i,
  input  wire logic two_stage_i,
  input  wire logic d_i,
  output logic      q_o
);

  clock_ctrl_pkg::sync_state_t s_q;
  clock_ctrl_pkg::sync_state_t s_d;

  // The first stage feeds only the second; one-stage mode bypasses it.
  always_comb begin
    s_d = s_q;
    if (en_i) begin
      s_d.s1 = d_i;
      s_d.s2 = two_stage_i ? s_q.s1 : d_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_o = s_q.s2;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  two_stage_a : assert property ((en_i && two_stage_i) |=> q_o == $past(s_q.s1))
    else $error("Two-stage ready path did not take the first stage.");
  hold_a : assert property (!en_i |=> $stable(q_o))
    else $error("Ready changed without a processor clock edge.");

endmodule : ready_sync

`default_nettype wire

/* bus_ready_model.sv */
// Bus device model that answers transfers with ready after a chosen wait.
`timescale 1ns/1ps
`default_nettype none

module bus_ready_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       go_a_i,
  input  wire logic       go_b_i,
  input  wire logic       skip_qual_i,
  input  wire logic [3:0] wait_i,
  output logic            bus_ready_a_o,
  output logic            bus_ready_b_o,
  output logic            addr_qualify_a_n_o,
  output logic            addr_qualify_b_n_o
);
  logic [3:0] cnt_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
    end else if (!(go_a_i || go_b_i)) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'hf) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // Ready rises when the transfer completes and falls when it ends.
  assign bus_ready_a_o      = go_a_i && (cnt_q >= wait_i);
  assign bus_ready_b_o      = go_b_i && (cnt_q >= wait_i);
  assign addr_qualify_a_n_o = !(go_a_i && !skip_qual_i);
  assign addr_qualify_b_n_o = !(go_b_i && !skip_qual_i);
endmodule : bus_ready_model

`default_nettype wire

/* test_static_clock_ready_controller.sv */
// Testbench of the static clock and ready controller.
`timescale 1ns/1ps
`default_nettype none
`include "clock_ctrl_map.svh"

module test_static_clock_ready_controller;
  logic        clk_i, reset_n_i, depth, speed, res_n, counter_sync, start, s0, s1, s2n;
  logic        psel, penable, pwrite, go_a, go_b, skip_q, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0]  wait_c;
  wire logic [31:0] prdata;
  wire logic   pready, pslverr, ready_o, pclk_w, half_w, per_w, osc_w, rst_o;
  wire logic   rdy_a, rdy_b, q_a_n, q_b_n;
  int          num_errors, n_checks, cyc, k, n1, n2, i;
  logic        last;

  static_clock_ready_controller #(.OSC_RESTART_CYCLES(16)) u_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .bus_ready_a_i(rdy_a), .bus_ready_b_i(rdy_b),
    .addr_qualify_a_n_i(q_a_n), .addr_qualify_b_n_i(q_b_n), .ready_sync_depth_sel_i(depth),
    .speed_select_i(speed), .reset_request_n_i(res_n), .counter_sync_i(counter_sync),
    .start_request_i(start), .status_line_0_i(s0), .status_line_1_i(s1),
    .status_line_2_stop_n_i(s2n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ready_o(ready_o), .proc_clock_o(pclk_w), .half_duty_clock_o(half_w),
    .periph_clock_o(per_w), .oscillator_out_o(osc_w), .reset_out_o(rst_o));

  bus_ready_model u_bus (
    .clk_i(clk_i), .rst_n_i(reset_n_i), .go_a_i(go_a), .go_b_i(go_b), .skip_qual_i(skip_q),
    .wait_i(wait_c), .bus_ready_a_o(rdy_a), .bus_ready_b_o(rdy_b),
    .addr_qualify_a_n_o(q_a_n), .addr_qualify_b_n_o(q_b_n));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic results();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      results();
    end
  end

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    w = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      w++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  function automatic logic pick(input int s);
    return (s == 0) ? pclk_w : (s == 1) ? per_w : half_w;
  endfunction : pick

  // Waits for a rising edge of the chosen clock output; c counts clk cycles.
  task automatic rise(input int s, output int c);
    c = 0;
    while (pick(s) !== 1'b0 && c < 2000) begin
      @(posedge clk_i);
      c++;
    end
    while (pick(s) !== 1'b1 && c < 2000) begin
      @(posedge clk_i);
      c++;
    end
  endtask : rise

  task automatic per_chk(input int s, input int p, input string msg);
    rise(s, k);
    rise(s, k);
    chk(k == p, msg);
  endtask : per_chk

  task automatic ready_lat(input logic dsel, output int n);
    depth <= dsel;
    go_a <= 1'b0;
    repeat (12) @(posedge clk_i);
    rise(0, k);
    go_a <= 1'b1;
    n = 0;
    while (ready_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    go_a <= 1'b0;
  endtask : ready_lat

  task automatic halt_stop();
    rise(0, k);
    {s2n, s1, s0} <= 3'b011;
    repeat (3) @(posedge clk_i);
    {s2n, s1, s0} <= 3'b111;
    repeat (20) @(posedge clk_i);
  endtask : halt_stop

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n_i, counter_sync, start, go_a, go_b, skip_q, psel, penable, pwrite} = '0;
    {depth, speed, res_n, s0, s1, s2n} = '1;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    wait_c = 4'h0;
    num_errors = 0;
    n_checks = 0;
    cyc = 0;
    repeat (2) @(posedge clk_i);
    chk(pclk_w === 1'b1 && per_w === 1'b1 && rst_o === 1'b1, "reset levels");
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    apb(1'b0, `ADDR_CTRL, 32'h0000_0000);
    chk(rd === `CTRL_RESET && err === 1'b0, "ctrl reset value");
    chk(pclk_w === 1'b1 && half_w === 1'b1, "clocks held in restart");
    apb(1'b1, 12'h010, 32'h0000_00ff);
    chk(err === 1'b1, "unmapped write error");
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(err === 1'b1 && rd === 32'h0000_0000, "unmapped read");
    n1 = 0;
    while (rst_o !== 1'b0 && n1 < 100) begin
      rise(0, k);
      n1++;
    end
    chk(n1 >= 16 && n1 < 100, "reset output width");
    per_chk(0, 3, "fast period");
    per_chk(2, 3, "half duty period");
    per_chk(1, 6, "periph period");
    speed <= 1'b0;
    repeat (100) @(posedge clk_i);
    speed <= 1'b1;
    repeat (10) @(posedge clk_i);
    per_chk(0, 3, "short slow request ignored");
    speed <= 1'b0;
    repeat (1000) @(posedge clk_i);
    per_chk(0, 768, "slow period");
    per_chk(1, 6, "periph period in slow");
    apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
    chk(rd[`STAT_SLOW_BIT] === 1'b1, "slow status");
    speed <= 1'b1;
    rise(0, k);
    rise(0, k);
    per_chk(0, 3, "back to fast");
    ready_lat(1'b1, n1);
    ready_lat(1'b0, n2);
    chk(n1 <= 6, "one stage ready latency");
    chk(n2 == n1 + 3, "two stage ready latency");
    depth <= 1'b1;
    skip_q <= 1'b1;
    go_a <= 1'b1;
    go_b <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk(ready_o === 1'b0, "unqualified ready ignored");
    skip_q <= 1'b0;
    go_a <= 1'b0;
    go_b <= 1'b0;
    wait_c <= 4'h9;
    @(posedge clk_i);
    go_b <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(ready_o === 1'b0, "slow device not ready");
    repeat (20) @(posedge clk_i);
    chk(ready_o === 1'b1, "second bus ready");
    go_b <= 1'b0;
    counter_sync <= 1'b1;
    repeat (4) @(posedge clk_i);
    for (i = 0; i < 10; i++) begin
      @(posedge clk_i);
      chk(pclk_w === 1'b1 && half_w === 1'b1 && per_w === 1'b1, "sync holds");
    end
    counter_sync <= 1'b0;
    per_chk(0, 3, "count after sync");
    halt_stop();
    last = per_w;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      chk(pclk_w === 1'b1 && half_w === 1'b1 && per_w === last, "stopped");
      chk(osc_w === 1'b1, "oscillator stopped high");
    end
    apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
    chk(rd[`STAT_STOPPED_BIT] === 1'b1 && rd[5:4] === 2'h2, "halt decoded");
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    rise(0, k);
    chk(k < 200, "restart by start");
    per_chk(0, 3, "clean restart");
    apb(1'b1, `ADDR_CTRL, 32'h0000_0001);
    halt_stop();
    last = osc_w;
    @(posedge clk_i);
    chk(osc_w === ~last, "oscillator runs in external mode");
    apb(1'b1, `ADDR_CTRL, 32'h0000_0003);
    rise(0, k);
    chk(k < 200, "restart by register");
    apb(1'b0, `ADDR_CTRL, 32'h0000_0000);
    chk(rd === 32'h0000_0001, "start bit reads zero");
    results();
  end
endmodule : test_static_clock_ready_controller

`default_nettype wire
